// ---- hdl/sred_defs.vh ----
// Constants for the serial receive error diagnostic block.
// Assumes a 100 MHz system clock and a plain register port.
`ifndef SRED_DEFS_VH
`define SRED_DEFS_VH

// Error weights in the diagnostic value.
`define SRED_W_PARITY    12'h0001
`define SRED_W_FRAMING   12'h0002
`define SRED_W_NOISE     12'h0004
`define SRED_W_OVERRUN   12'h0008
`define SRED_W_NODATA    12'h0200
`define SRED_W_CHECKSUM  12'h0400
`define SRED_W_WRONGDATA 12'h0800
`define SRED_DIAG_W      12

// Register offsets.
`define SRED_REG_CTRL    4'h0
`define SRED_REG_BAUD    4'h1
`define SRED_REG_DIAG    4'h2
`define SRED_REG_RXDATA  4'h3
`define SRED_REG_IRQ_ST  4'h4
`define SRED_REG_IRQ_MSK 4'h5
`define SRED_REG_HDR     4'h6
`define SRED_REG_PERIOD  4'h7

// Control fields.
`define SRED_CTRL_PAR_EN   0
`define SRED_CTRL_PAR_ODD  1
`define SRED_CTRL_TWO_STOP 2
`define SRED_CTRL_EN       3

// Reset values and the message length limit.
`define SRED_CTRL_RST    4'h8
`define SRED_BAUD_RST    16'h0364
`define SRED_HDR_RST     8'h82
`define SRED_LEN_MAX     8'h40

// Reporting interval: 100 ms at 100 MHz.
`define SRED_INTERVAL_NS  100000000
`define SRED_CLK_NS       10
`define SRED_INTERVAL_CYC (`SRED_INTERVAL_NS / `SRED_CLK_NS)

// Interrupt status bits.
`define SRED_IRQ_BYTE    0
`define SRED_IRQ_ERR     1
`define SRED_IRQ_MSG     2

`endif

// ---- hdl/sred_uart_rx.v ----
// Serial character receiver with parity and stop bit checks.
// Assumes rxd is already synchronous to clk; baud_div is cycles per bit.
`timescale 1ns/10ps
`default_nettype none
module sred_uart_rx (
   input  wire        clk,
   input  wire        rst,
   input  wire        rxd,
   input  wire [15:0] baud_div,
   input  wire        par_en,
   input  wire        par_odd,
   input  wire        two_stop,
   output reg         rx_valid,
   output reg  [7:0]  rx_byte,
   output reg         par_err,
   output reg         frm_err
);
   localparam ST_IDLE  = 5'b00001;
   localparam ST_START = 5'b00010;
   localparam ST_DATA  = 5'b00100;
   localparam ST_PAR   = 5'b01000;
   localparam ST_STOP  = 5'b10000;

   reg [4:0]  state;
   reg [15:0] cnt;
   reg [2:0]  bit_idx;
   reg        stop_idx;
   reg [7:0]  shreg;
   reg        par_bit;
   wire       tick = (cnt == 16'h0000);
   wire [15:0] half = {1'b0, baud_div[15:1]};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state    <= ST_IDLE;
         cnt      <= 16'h0000;
         bit_idx  <= 3'd0;
         stop_idx <= 1'b0;
         shreg    <= 8'h00;
         par_bit  <= 1'b0;
         rx_valid <= 1'b0;
         rx_byte  <= 8'h00;
         par_err  <= 1'b0;
         frm_err  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (!tick)
            cnt <= cnt - 16'h0001;
         case (state)
            ST_IDLE: begin
               if (!rxd) begin
                  cnt   <= half;
                  state <= ST_START;
               end
            end
            ST_START: if (tick) begin
               if (rxd) begin
                  state <= ST_IDLE;
               end else begin
                  cnt     <= baud_div - 16'h0001;
                  bit_idx <= 3'd0;
                  state   <= ST_DATA;
               end
            end
            ST_DATA: if (tick) begin
               shreg <= {rxd, shreg[7:1]};
               cnt   <= baud_div - 16'h0001;
               bit_idx <= bit_idx + 3'd1;
               if (bit_idx == 3'd7)
                  state <= par_en ? ST_PAR : ST_STOP;
               stop_idx <= 1'b0;
            end
            ST_PAR: if (tick) begin
               par_bit <= rxd;
               cnt     <= baud_div - 16'h0001;
               state   <= ST_STOP;
            end
            ST_STOP: if (tick) begin
               cnt <= baud_div - 16'h0001;
               if (!rxd || !(two_stop && !stop_idx)) begin
                  // A low stop bit ends the character at once as a framing fault.
                  rx_valid <= 1'b1;
                  rx_byte  <= shreg;
                  par_err  <= par_en && ((^shreg ^ par_bit) != par_odd);
                  frm_err  <= !rxd;
                  state    <= rxd ? ST_IDLE : ST_IDLE;
               end else begin
                  stop_idx <= 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // sred_uart_rx
`default_nettype wire

// ---- hdl/sred_msg_check.v ----
// Message checker: header search, length, payload checksum.
// Frame: header byte, length byte (1..max), payload, checksum = sum of all.
`timescale 1ns/10ps
`default_nettype none
`include "sred_defs.vh"
module sred_msg_check (
   input  wire       clk,
   input  wire       rst,
   input  wire       byte_valid,
   input  wire [7:0] byte_data,
   input  wire [7:0] header,
   output reg        hdr_seen,
   output reg        msg_ok,
   output reg        sum_err,
   output reg        bad_data
);
   localparam ST_HUNT = 4'b0001;
   localparam ST_LEN  = 4'b0010;
   localparam ST_BODY = 4'b0100;
   localparam ST_SUM  = 4'b1000;

   reg [3:0] state;
   reg [7:0] left;
   reg [7:0] sum;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state    <= ST_HUNT;
         left     <= 8'h00;
         sum      <= 8'h00;
         hdr_seen <= 1'b0;
         msg_ok   <= 1'b0;
         sum_err  <= 1'b0;
         bad_data <= 1'b0;
      end else begin
         hdr_seen <= 1'b0;
         msg_ok   <= 1'b0;
         sum_err  <= 1'b0;
         bad_data <= 1'b0;
         if (byte_valid) begin
            case (state)
               ST_HUNT: if (byte_data == header) begin
                  hdr_seen <= 1'b1;
                  sum      <= byte_data;
                  state    <= ST_LEN;
               end
               ST_LEN: begin
                  if (byte_data == 8'h00 || byte_data > `SRED_LEN_MAX) begin
                     bad_data <= 1'b1;
                     state    <= ST_HUNT;
                  end else begin
                     left  <= byte_data;
                     sum   <= sum + byte_data;
                     state <= ST_BODY;
                  end
               end
               ST_BODY: begin
                  sum  <= sum + byte_data;
                  left <= left - 8'h01;
                  if (left == 8'h01)
                     state <= ST_SUM;
               end
               ST_SUM: begin
                  msg_ok  <= (byte_data == sum);
                  sum_err <= (byte_data != sum);
                  state   <= ST_HUNT;
               end
               default: state <= ST_HUNT;
            endcase
         end
      end
   end
endmodule // sred_msg_check
`default_nettype wire

// ---- hdl/sred_diag.v ----
// Serial link error diagnostic: receiver, message checker, weighted code.
// Assumes rxd synchronous to clk and a one-cycle register port.
//
// What this block does
// - Sum active error weights into one value.
// - Parity mismatch sets weight one.
// - Missing stop bit sets weight two.
// - Noise weight four always reads zero.
// - Unread byte overwritten sets overrun weight.
// - No valid header in interval sets 512.
// - Header found, bad checksum sets 1024.
// - Undecodable content sets weight 2048.
// - Diagnostic value readable as its own channel.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sred_defs.vh"
module sred_diag #(
   parameter [31:0] INTERVAL_CYC = `SRED_INTERVAL_CYC
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        rxd,
   input  wire [3:0]  addr,
   input  wire [15:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [15:0] rdata,
   output wire        irq,
   output reg  [11:0] serial_link_error_channel
);
   reg [3:0]  ctrl;
   reg [15:0] baud_div;
   reg [7:0]  header;
   reg [2:0]  irq_st;
   reg [2:0]  irq_msk;
   reg [7:0]  data_hold;
   reg        data_full;
   reg [11:0] acc;
   reg [31:0] ivl_cnt;
   reg [15:0] msg_cnt;
   reg [15:0] msg_rate;

   wire       rx_valid;
   wire [7:0] rx_byte;
   wire       par_err;
   wire       frm_err;
   wire       hdr_seen;
   wire       msg_ok;
   wire       sum_err;
   wire       bad_data;
   wire       en = ctrl[`SRED_CTRL_EN];

   sred_uart_rx u_rx (
      .clk      (clk),
      .rst      (rst),
      .rxd      (rxd | ~en),
      .baud_div (baud_div),
      .par_en   (ctrl[`SRED_CTRL_PAR_EN]),
      .par_odd  (ctrl[`SRED_CTRL_PAR_ODD]),
      .two_stop (ctrl[`SRED_CTRL_TWO_STOP]),
      .rx_valid (rx_valid),
      .rx_byte  (rx_byte),
      .par_err  (par_err),
      .frm_err  (frm_err)
   );

   // Only clean characters feed the message checker.
   wire good_byte = rx_valid & ~par_err & ~frm_err;

   sred_msg_check u_msg (
      .clk        (clk),
      .rst        (rst),
      .byte_valid (good_byte),
      .byte_data  (rx_byte),
      .header     (header),
      .hdr_seen   (hdr_seen),
      .msg_ok     (msg_ok),
      .sum_err    (sum_err),
      .bad_data   (bad_data)
   );

   wire rd_data  = rd && (addr == `SRED_REG_RXDATA);
   wire ivl_end  = (ivl_cnt == INTERVAL_CYC - 32'd1);
   wire overrun  = rx_valid && data_full && !rd_data;

   // Weights seen in this cycle; the noise weight is never produced.
   wire [11:0] hits =
      ((rx_valid && par_err) ? `SRED_W_PARITY    : 12'h000) |
      ((rx_valid && frm_err) ? `SRED_W_FRAMING   : 12'h000) |
      (overrun               ? `SRED_W_OVERRUN   : 12'h000) |
      (sum_err               ? `SRED_W_CHECKSUM  : 12'h000) |
      (bad_data              ? `SRED_W_WRONGDATA : 12'h000);

   // A header seen anywhere in the interval clears the no-data condition.
   reg hdr_in_ivl;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ivl_cnt    <= 32'd0;
         acc        <= 12'h000;
         hdr_in_ivl <= 1'b0;
         msg_cnt    <= 16'h0000;
         msg_rate   <= 16'h0000;
         serial_link_error_channel <= 12'h000;
      end else begin
         if (ivl_end) begin
            ivl_cnt <= 32'd0;
            // The code published at an interval end stays for the whole next
            // interval, so a single event is visible for at least one interval.
            serial_link_error_channel <= (acc | hits |
               ((hdr_in_ivl || hdr_seen) ? 12'h000 : `SRED_W_NODATA))
               & ~`SRED_W_NOISE;
            acc        <= 12'h000;
            hdr_in_ivl <= 1'b0;
            msg_rate   <= msg_cnt + {15'd0, msg_ok};
            msg_cnt    <= 16'h0000;
         end else begin
            ivl_cnt    <= ivl_cnt + 32'd1;
            acc        <= acc | hits;
            hdr_in_ivl <= hdr_in_ivl | hdr_seen;
            if (msg_ok)
               msg_cnt <= msg_cnt + 16'h0001;
         end
      end
   end

   // Receive holding register; a read empties it, a new byte without parity or framing error fills it.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         data_hold <= 8'h00;
         data_full <= 1'b0;
      end else begin
         if (rx_valid && !par_err && !frm_err) begin
            data_hold <= rx_byte;
            data_full <= 1'b1;
         end else if (rd_data) begin
            data_full <= 1'b0;
         end
      end
   end

   wire [2:0] irq_ev;
   assign irq_ev[`SRED_IRQ_BYTE] = good_byte;
   assign irq_ev[`SRED_IRQ_ERR]  = |hits;
   assign irq_ev[`SRED_IRQ_MSG]  = msg_ok;
   assign irq = |(irq_st & irq_msk);

   wire [2:0] irq_clr = (wr && addr == `SRED_REG_IRQ_ST) ? wdata[2:0] : 3'b000;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl     <= `SRED_CTRL_RST;
         baud_div <= `SRED_BAUD_RST;
         header   <= `SRED_HDR_RST;
         irq_msk  <= 3'b000;
         irq_st   <= 3'b000;
      end else begin
         // A new event beats a clear in the same cycle.
         irq_st <= (irq_st & ~irq_clr) | irq_ev;
         if (wr) begin
            case (addr)
               `SRED_REG_CTRL:    ctrl     <= wdata[3:0];
               `SRED_REG_BAUD:    baud_div <= (wdata < 16'h0004) ? 16'h0004 : wdata;
               `SRED_REG_HDR:     header   <= wdata[7:0];
               `SRED_REG_IRQ_MSK: irq_msk  <= wdata[2:0];
               default: ;
            endcase
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= 16'h0000;
         if (rd) begin
            case (addr)
               `SRED_REG_CTRL:    rdata <= {12'h000, ctrl};
               `SRED_REG_BAUD:    rdata <= baud_div;
               `SRED_REG_DIAG:    rdata <= {4'h0, serial_link_error_channel};
               `SRED_REG_RXDATA:  rdata <= {7'h00, data_full, data_hold};
               `SRED_REG_IRQ_ST:  rdata <= {13'h0000, irq_st};
               `SRED_REG_IRQ_MSK: rdata <= {13'h0000, irq_msk};
               `SRED_REG_HDR:     rdata <= {8'h00, header};
               `SRED_REG_PERIOD:  rdata <= msg_rate;
               default:           rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule // sred_diag
`default_nettype wire

// ---- verif/sred_diag_props.sv ----
// Port checker for the serial error diagnostic block.
// Bound to sred_diag; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sred_diag_props #(
   parameter [31:0] INTERVAL_CYC = 32'h0000_07D0
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        rxd,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        irq,
   input wire logic [11:0] serial_link_error_channel
);
   wire logic [11:0] ch = serial_link_error_channel;
   logic [31:0]      hold_cnt;
   logic [31:0]      idle_cnt;
   logic [2:0]       msk;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // A byte may finish well after the line goes idle, so idle is judged over three intervals.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_cnt <= 32'h0000_0000;
         idle_cnt <= 32'h0000_0000;
         msk      <= 3'h0;
      end else begin
         hold_cnt <= $changed(ch) ? 32'h0000_0000 : hold_cnt + 1;
         idle_cnt <= rxd ? idle_cnt + 1 : 32'h0000_0000;
         if (wr && addr == 4'h5)
            msk <= wdata[2:0];
      end
   end
   sequence s_diag_rd;
      rd && addr == 4'h2;
   endsequence
   sequence s_bad_rd;
      rd && addr > 4'h7;
   endsequence
   a_noise_zero: assert property (ch[2] == 1'b0)
      else $error("noise weight set");
   a_unused_zero: assert property (ch[8:4] == 5'h00)
      else $error("undefined weight set");
   a_rdata_quiet: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data without read");
   a_diag_read: assert property (s_diag_rd |=> rdata == {4'h0, $past(ch)})
      else $error("diag read differs from channel");
   a_unmapped_read: assert property (s_bad_rd |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_chan_hold: assert property ($changed(ch) |-> hold_cnt >= INTERVAL_CYC - 32'd1)
      else $error("channel changed inside interval");
   a_idle_nodata: assert property (idle_cnt > 3 * INTERVAL_CYC |-> ch == 12'h200)
      else $error("idle line not no data");
   a_irq_masked: assert property (msk == 3'h0 |-> !irq)
      else $error("irq with all masked");
endmodule // sred_diag_props
bind sred_diag sred_diag_props #(.INTERVAL_CYC(INTERVAL_CYC)) i_sred_diag_props (
   .clk(clk), .rst(rst), .rxd(rxd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .irq(irq), .serial_link_error_channel(serial_link_error_channel));
`default_nettype wire

// ---- verif/sred_tx_model.sv ----
// Serial sender standing in for the telemetry source.
// Line idles high; the bench paces characters.
`timescale 1ns/10ps
`default_nettype none
module sred_tx_model (
   input  wire logic clk,
   output var  logic txd
);
   initial txd = 1'b1;
   // Parity 0 none, 1 even, 2 odd; bad flips it, brk drops the stop bit.
   // Callers send one message per interval at most.
   task automatic send(input logic [7:0] b, input int bt, input int par,
                       input bit bad, input bit brk);
      logic [11:0] f;
      int          n;
      logic        p;
      p = (^b) ^ (par == 2) ^ bad;
      n = (par == 0) ? 10 : 11;
      f = (par == 0) ? {2'b11, ~brk, b, 1'b0} : {1'b1, ~brk, p, b, 1'b0};
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         txd <= f[i];
         repeat (bt - 1) @(posedge clk);
      end
      @(posedge clk);
      txd <= 1'b1;
   endtask
endmodule // sred_tx_model
`default_nettype wire

// ---- verif/test_sred_diag.sv ----
// Bench for the serial error diagnostic block.
// Drives the register port and a sender model on rxd.
`timescale 1ns/10ps
`default_nettype none
module test_sred_diag;
   localparam int IV = 4000;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   wire logic        rxd;
   wire logic [15:0] rdata;
   wire logic        irq;
   wire logic [11:0] chan;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   always @(posedge clk or posedge rst) begin
      if (rst)
         cyc <= 0;
      else
         cyc <= cyc + 1;
   end
   sred_diag #(.INTERVAL_CYC(IV)) i_sred_diag (.clk(clk), .rst(rst), .rxd(rxd),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .serial_link_error_channel(chan));
   sred_tx_model i_sred_tx_model (.clk(clk), .txd(rxd));
   task stop_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask
   task wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rchk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask
   task sb(input logic [7:0] b, input int par, input bit bad, input bit brk, input bit rdb);
      i_sred_tx_model.send(b, 16, par, bad, brk);
      if (rdb)
         rchk(4'h3, {7'h00, 1'b1, b});
   endtask
   task msg(input logic [7:0] n, input logic [7:0] off);
      logic [7:0] s;
      s = 8'h82 + n;
      sb(8'h82, 0, 0, 0, 1);
      sb(n, 0, 0, 0, 1);
      for (int i = 0; i < n; i++) begin
         sb(8'h5A, 0, 0, 0, 1);
         s = s + 8'h5A;
      end
      sb(s + off, 0, 0, 0, 1);
   endtask
   task start(input logic [15:0] c);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wreg(4'h1, 16'h0010);
      wreg(4'h0, c);
   endtask
   task chan_is(input int t, input logic [15:0] e);
      while (cyc < t) @(posedge clk);
      #1;
      chk("chan", e, {4'h0, chan});
      rchk(4'h2, e);
   endtask
   initial begin
      repeat (70000) @(posedge clk);
      num_errors++;
      stop_test;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rchk(4'h0, 16'h0008);
      rchk(4'h1, 16'h0364);
      rchk(4'h6, 16'h0082);
      rchk(4'h5, 16'h0000);
      rchk(4'hF, 16'h0000);
      // Rates below four cycles per bit are raised to four.
      wreg(4'h1, 16'h0002);
      rchk(4'h1, 16'h0004);
      wreg(4'h6, 16'h00A5);
      rchk(4'h6, 16'h00A5);
      start(16'h0008);
      msg(8'h02, 8'h00);
      chan_is(IV * 3 / 2, 16'h0000);
      rchk(4'h7, 16'h0001);
      start(16'h0009);
      wreg(4'h5, 16'h0002);
      sb(8'h82, 1, 1, 0, 0);
      #1;
      chk("irq", 16'h0001, {15'h0000, irq});
      wreg(4'h4, 16'h0002);
      #1;
      chk("irq", 16'h0000, {15'h0000, irq});
      // The odd setting must raise its own error after the clear.
      wreg(4'h0, 16'h000B);
      sb(8'h82, 2, 1, 0, 0);
      #1;
      chk("irq", 16'h0001, {15'h0000, irq});
      chan_is(IV * 3 / 2, 16'h0201);
      start(16'h0008);
      sb(8'h82, 0, 0, 1, 0);
      chan_is(IV * 3 / 2, 16'h0202);
      // Two stop bits: the next start bit lands on the second stop bit.
      start(16'h000C);
      sb(8'h82, 0, 0, 0, 0);
      sb(8'hFF, 0, 0, 0, 0);
      chan_is(IV * 3 / 2, 16'h0202);
      start(16'h0008);
      sb(8'h55, 0, 0, 0, 0);
      sb(8'h55, 0, 0, 0, 0);
      chan_is(IV * 3 / 2, 16'h0208);
      start(16'h0008);
      msg(8'h01, 8'h01);
      chan_is(IV * 3 / 2, 16'h0400);
      start(16'h0008);
      sb(8'h82, 0, 0, 0, 1);
      sb(8'h00, 0, 0, 0, 1);
      sb(8'h82, 0, 0, 0, 1);
      sb(8'h41, 0, 0, 0, 1);
      chan_is(IV * 3 / 2, 16'h0800);
      chan_is(IV * 5 / 2, 16'h0200);
      chan_is(IV * 4, 16'h0200);
      stop_test;
   end
endmodule // test_sred_diag
`default_nettype wire
